// >>> verilog/dsmv_pkg.sv
package dsmv_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTL1 = 10'h005;
    localparam logic [9:0] IDX_CTL2 = 10'h006;
    localparam logic [9:0] IDX_GAIN_L = 10'h00A;
    localparam logic [9:0] IDX_GAIN_R = 10'h00B;
    localparam logic [9:0] IDX_ALIAS = 10'h031;
    localparam logic [9:0] IDX_STATUS = 10'h032;

    // Field positions
    localparam int CTL1_SOFT_MUTE_BIT = 4;
    localparam int CTL1_MUTE_BIT = 3;
    localparam int CTL2_SOFT_UNMUTE_BIT = 3;
    localparam int CTL2_RATE_BIT = 2;
    localparam int GAIN_STROBE_BIT = 8;
    localparam int ALIAS_MUTE_BIT = 4;
    localparam int STATUS_BUSY_BIT = 16;

    // Reset values
    localparam logic RST_MUTE = 1'b1;
    localparam logic RST_SOFT_MUTE = 1'b1;
    localparam logic RST_SOFT_UNMUTE = 1'b1;
    localparam logic RST_RATE = 1'b0;
    localparam logic [7:0] RST_GAIN = 8'hC0;

    // Gain law: 16 codes per octave, code 0xC0 is unity
    localparam int GAIN_SHIFT_BASE = 27;
    localparam logic [7:0] ATTEN_FULL = 8'hFF;

    // Ramp timing, longest full ramp at the reference sample rate
    localparam int RAMP_FAST_US = 10700;
    localparam int RAMP_SLOW_US = 171000;
    localparam int REF_FS_KHZ = 48;
    localparam int RAMP_STEPS = 255;
    // Longest times round down to whole sample periods per step
    localparam int RAMP_FAST_SPS = (RAMP_FAST_US * REF_FS_KHZ) /
        (1000 * RAMP_STEPS);
    localparam int RAMP_SLOW_SPS = (RAMP_SLOW_US * REF_FS_KHZ) /
        (1000 * RAMP_STEPS);

    localparam int SMP_W = 24;

    typedef struct packed {
        logic [1:0][SMP_W-1:0] ch; // Index 0 left, 1 right
    } dsmv_stereo_t;

    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_DOWN = 2'b01,
        RAMP_UP = 2'b10
    } dsmv_ramp_t;
endpackage

// >>> verilog/dsmv_gain_stage.sv
`timescale 1ns/1ps
module dsmv_gain_stage #(
    parameter int W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic signed [W-1:0] in_smp,
    input wire logic [7:0] code,
    output logic signed [W-1:0] out_smp
);
    // Fractional octave mantissa, 2^(k/16) in Q1.15
    function automatic logic [15:0] mant(input logic [3:0] k);
        case (k)
            4'h0: mant = 16'h8000;
            4'h1: mant = 16'h85AB;
            4'h2: mant = 16'h8B96;
            4'h3: mant = 16'h91C4;
            4'h4: mant = 16'h9838;
            4'h5: mant = 16'h9EF5;
            4'h6: mant = 16'hA5FF;
            4'h7: mant = 16'hAD58;
            4'h8: mant = 16'hB505;
            4'h9: mant = 16'hBD08;
            4'hA: mant = 16'hC567;
            4'hB: mant = 16'hCE24;
            4'hC: mant = 16'hD745;
            4'hD: mant = 16'hE0CD;
            4'hE: mant = 16'hEAC1;
            default: mant = 16'hF525;
        endcase
    endfunction

    logic signed [W+16:0] prod;
    logic signed [W+16:0] scaled;
    logic [4:0] shamt;
    localparam logic signed [W+16:0] MAXV = (W+17)'((1 <<< (W-1)) - 1);
    localparam logic signed [W+16:0] MINV = -(W+17)'(1 <<< (W-1));

    // Gain is 0.375 dB per code: mantissa times a power of two
    assign prod = in_smp * $signed({1'b0, mant(code[3:0])});
    assign shamt = 5'(dsmv_pkg::GAIN_SHIFT_BASE) - {1'b0, code[7:4]};
    assign scaled = prod >>> shamt;

    // Saturate instead of wrapping, since codes above 0xC0 add gain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_smp <= '0;
        end else if (in_valid) begin
            if (code == 8'h00) begin
                out_smp <= '0;
            end else if (scaled > MAXV) begin
                out_smp <= MAXV[W-1:0];
            end else if (scaled < MINV) begin
                out_smp <= MINV[W-1:0];
            end else begin
                out_smp <= scaled[W-1:0];
            end
        end
    end
endmodule

// >>> verilog/dsmv_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Mute bit set silences playback; cleared passes samples at programmed gain.
// - Mute bit resets to 1, so playback starts muted.
// - Soft-mute off: muting drops gain to silence at once.
// - Soft-mute on: muting steps gain down until the signal reaches zero.
// - Soft-unmute off: unmuting restores the current gain codes at once.
// - Soft-unmute on: unmuting steps gain up to the current gain codes.
// - Ramp speed bit picks fast (10.7 ms max) or slow (171 ms max).
// - Ramp time counts sample periods; figures hold at 48 kHz.
// - Mute bit appears at two addresses sharing one storage bit.
// - Gain codes step linearly in 0.375 dB; 0xFF is +23.625 dB.
// - Code X gives 0.375*(X-192) dB; code zero is digital mute.
// - New gain codes wait for the update strobe, then apply together.
module dsmv_top #(
    parameter int RAMP_FAST_SPS = dsmv_pkg::RAMP_FAST_SPS,
    parameter int RAMP_SLOW_SPS = dsmv_pkg::RAMP_SLOW_SPS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dsmv_pkg::dsmv_stereo_t smp_in,
    input wire logic smp_in_valid,
    output dsmv_pkg::dsmv_stereo_t smp_out,
    output logic smp_out_valid
);
    localparam int CW = $clog2(RAMP_SLOW_SPS + 1);

    logic ack_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic [31:0] rd_mux;
    logic hit;
    logic [9:0] idx;
    logic wr_en;
    logic mute_q;
    logic soft_mute_q;
    logic soft_unmute_q;
    logic rate_q;
    logic [1:0][7:0] pend_q;
    logic [1:0][7:0] act_q;
    logic [1:0][7:0] app_code;
    logic [7:0] atten_q;
    logic [7:0] top_code;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] sps_last;
    logic step_en;
    logic strobe;
    dsmv_pkg::dsmv_ramp_t ramp_st;

    assign idx = paddr[11:2];
    assign wr_en = psel && penable && ack_q && pwrite;

    // Address decode; anything outside the map answers with an error
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (idx)
            dsmv_pkg::IDX_CTL1: begin
                rd_mux[dsmv_pkg::CTL1_SOFT_MUTE_BIT] = soft_mute_q;
                rd_mux[dsmv_pkg::CTL1_MUTE_BIT] = mute_q;
            end
            dsmv_pkg::IDX_CTL2: begin
                rd_mux[dsmv_pkg::CTL2_SOFT_UNMUTE_BIT] = soft_unmute_q;
                rd_mux[dsmv_pkg::CTL2_RATE_BIT] = rate_q;
            end
            dsmv_pkg::IDX_GAIN_L: rd_mux[7:0] = pend_q[0];
            dsmv_pkg::IDX_GAIN_R: rd_mux[7:0] = pend_q[1];
            dsmv_pkg::IDX_ALIAS: begin
                rd_mux[dsmv_pkg::ALIAS_MUTE_BIT] = mute_q;
            end
            dsmv_pkg::IDX_STATUS: begin
                rd_mux[7:0] = app_code[0];
                rd_mux[15:8] = app_code[1];
                rd_mux[dsmv_pkg::STATUS_BUSY_BIT] =
                    (ramp_st != dsmv_pkg::RAMP_IDLE);
            end
            default: hit = 1'b0;
        endcase
    end

    // One wait state so read data and the error flag come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            ack_q <= psel && penable && !ack_q;
            if (psel && penable && !ack_q) begin
                rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
                err_q <= !hit;
            end
        end
    end

    assign pready = ack_q;
    assign prdata = rdata_q;
    assign pslverr = ack_q && err_q;

    // Either address writes the same mute flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute_q <= dsmv_pkg::RST_MUTE;
        end else if (wr_en && idx == dsmv_pkg::IDX_CTL1) begin
            mute_q <= pwdata[dsmv_pkg::CTL1_MUTE_BIT];
        end else if (wr_en && idx == dsmv_pkg::IDX_ALIAS) begin
            mute_q <= pwdata[dsmv_pkg::ALIAS_MUTE_BIT];
        end
    end

    // Ramp options
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_mute_q <= dsmv_pkg::RST_SOFT_MUTE;
            soft_unmute_q <= dsmv_pkg::RST_SOFT_UNMUTE;
            rate_q <= dsmv_pkg::RST_RATE;
        end else if (wr_en && idx == dsmv_pkg::IDX_CTL1) begin
            soft_mute_q <= pwdata[dsmv_pkg::CTL1_SOFT_MUTE_BIT];
        end else if (wr_en && idx == dsmv_pkg::IDX_CTL2) begin
            soft_unmute_q <= pwdata[dsmv_pkg::CTL2_SOFT_UNMUTE_BIT];
            rate_q <= pwdata[dsmv_pkg::CTL2_RATE_BIT];
        end
    end

    // A strobe written with either code applies both channels at once
    assign strobe = wr_en && pwdata[dsmv_pkg::GAIN_STROBE_BIT] &&
        (idx == dsmv_pkg::IDX_GAIN_L || idx == dsmv_pkg::IDX_GAIN_R);

    // Pending codes are held apart so a half-written pair never plays
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= {dsmv_pkg::RST_GAIN, dsmv_pkg::RST_GAIN};
            act_q <= {dsmv_pkg::RST_GAIN, dsmv_pkg::RST_GAIN};
        end else begin
            if (wr_en && idx == dsmv_pkg::IDX_GAIN_L) begin
                pend_q[0] <= pwdata[7:0];
            end
            if (wr_en && idx == dsmv_pkg::IDX_GAIN_R) begin
                pend_q[1] <= pwdata[7:0];
            end
            if (strobe) begin
                // The code written with the strobe takes effect too
                act_q[0] <= (idx == dsmv_pkg::IDX_GAIN_L) ?
                    pwdata[7:0] : pend_q[0];
                act_q[1] <= (idx == dsmv_pkg::IDX_GAIN_R) ?
                    pwdata[7:0] : pend_q[1];
            end
        end
    end

    // Louder of the two active codes; once attenuation reaches it,
    // both channels are silent and a soft mute has nothing left to do
    assign top_code = (act_q[0] > act_q[1]) ? act_q[0] : act_q[1];

    // Ramp direction follows mute and the current attenuation
    always_comb begin
        if (mute_q && atten_q < top_code) begin
            ramp_st = dsmv_pkg::RAMP_DOWN;
        end else if (!mute_q && atten_q != 8'h00) begin
            ramp_st = dsmv_pkg::RAMP_UP;
        end else begin
            ramp_st = dsmv_pkg::RAMP_IDLE;
        end
    end

    // Step rate in sample periods, so ramp time scales with fs
    assign sps_last = rate_q ? CW'(RAMP_SLOW_SPS - 1) :
        CW'(RAMP_FAST_SPS - 1);
    assign step_en = smp_in_valid && cnt_q == sps_last;

    // Sample period counter; restarts whenever no ramp is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (ramp_st == dsmv_pkg::RAMP_IDLE) begin
            cnt_q <= '0;
        end else if (smp_in_valid) begin
            cnt_q <= (cnt_q >= sps_last) ? '0 : cnt_q + 1'b1;
        end
    end

    // Attenuation in code steps; a mid-ramp reversal turns from here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            atten_q <= dsmv_pkg::ATTEN_FULL;
        end else begin
            case (ramp_st)
                dsmv_pkg::RAMP_DOWN: begin
                    if (!soft_mute_q) begin
                        atten_q <= dsmv_pkg::ATTEN_FULL;
                    end else if (step_en) begin
                        atten_q <= atten_q + 8'h01;
                    end
                end
                dsmv_pkg::RAMP_UP: begin
                    if (!soft_unmute_q) begin
                        atten_q <= 8'h00;
                    end else if (step_en) begin
                        atten_q <= atten_q - 8'h01;
                    end
                end
                default: atten_q <= atten_q;
            endcase
        end
    end

    // Applied code per channel; full attenuation always reaches code 0
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            assign app_code[c] = (atten_q >= act_q[c]) ? 8'h00 :
                act_q[c] - atten_q;
            dsmv_gain_stage #(
                .W(dsmv_pkg::SMP_W)
            ) u_gain (
                .pclk(pclk),
                .presetn(presetn),
                .in_valid(smp_in_valid),
                .in_smp(smp_in.ch[c]),
                .code(app_code[c]),
                .out_smp(smp_out.ch[c])
            );
        end
    endgenerate

    // Output valid lines up with the one-cycle gain stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_out_valid <= 1'b0;
        end else begin
            smp_out_valid <= smp_in_valid;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    silent_out_a: assert property (
        smp_in_valid && mute_q && app_code == '0
        |=> smp_out_valid && smp_out == '0)
        else $error("muted sample not silent");

    hard_mute_a: assert property (
        mute_q && !soft_mute_q |=> app_code == '0)
        else $error("hard mute did not jump to silence");

    soft_down_a: assert property (
        step_en && soft_mute_q && ramp_st == dsmv_pkg::RAMP_DOWN
        |=> atten_q == $past(atten_q) + 8'h01)
        else $error("soft mute step wrong");

    hard_unmute_a: assert property (
        !mute_q && !soft_unmute_q |=> atten_q == 8'h00)
        else $error("hard unmute did not restore gain");

    soft_up_a: assert property (
        step_en && !mute_q && soft_unmute_q && atten_q != 8'h00
        |=> atten_q == $past(atten_q) - 8'h01)
        else $error("soft unmute step wrong");

    step_rate_a: assert property (
        $changed(atten_q) && soft_mute_q && soft_unmute_q
        && $past(mute_q) == mute_q
        |-> $past(smp_in_valid) && $past(cnt_q) == $past(sps_last))
        else $error("ramp stepped off its sample period");

    alias_wr_a: assert property (
        wr_en && idx == dsmv_pkg::IDX_ALIAS
        |=> mute_q == $past(pwdata[dsmv_pkg::ALIAS_MUTE_BIT]))
        else $error("alias write missed mute bit");

    gain_hold_a: assert property (
        !strobe |=> $stable(act_q))
        else $error("gain changed without strobe");

    ramp_hold_a: assert property (
        !step_en && soft_mute_q && soft_unmute_q |=> $stable(atten_q))
        else $error("ramp moved between steps");

    apb_ack_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("access not answered in one wait state");
endmodule

// >>> verif/dsmv_smp_src.sv
`timescale 1ns/1ps
// Upstream sample source: one valid pulse per sample period
module dsmv_smp_src #(
    parameter int PER = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [dsmv_pkg::SMP_W-1:0] left,
    input wire logic [dsmv_pkg::SMP_W-1:0] right,
    output dsmv_pkg::dsmv_stereo_t smp_in,
    output logic smp_in_valid
);
    int cnt_q;

    // Valid rate is fs, so the ramp length is counted in these
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
            smp_in_valid <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
            smp_in_valid <= (cnt_q == PER - 1);
        end
    end

    // Off-valid lanes carry the inverse, so stale data cannot pass
    always_comb begin
        smp_in.ch[0] = smp_in_valid ? left : ~left;
        smp_in.ch[1] = smp_in_valid ? right : ~right;
    end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic smp_in_valid, smp_out_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] src_l, src_r;
    dsmv_pkg::dsmv_stereo_t smp_in, smp_out;
    int failures, check_count, vcount, x;

    dsmv_top #(.RAMP_FAST_SPS(2), .RAMP_SLOW_SPS(32)) i_dsmv_top (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .smp_in(smp_in), .smp_in_valid(smp_in_valid),
        .smp_out(smp_out), .smp_out_valid(smp_out_valid)
    );
    dsmv_smp_src #(.PER(4)) i_dsmv_smp_src (
        .pclk(pclk), .presetn(presetn), .left(src_l), .right(src_r),
        .smp_in(smp_in), .smp_in_valid(smp_in_valid)
    );

    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Sample periods seen so far, the time base of every ramp
    always @(posedge pclk) begin
        if (smp_in_valid === 1'b1) vcount++;
    end

    task tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        check_count++;
        if (seen !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, seen);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            tally_and_finish;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input string nm, input logic [9:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        chk(nm, rd, e);
    endtask

    // Second output after the call, so any gain change has landed
    task out_chk(input string nm, input logic [23:0] el, input logic [23:0] eg);
        int n, k;
        n = 0;
        k = 0;
        while (k < 2 && n < 100) begin
            @(posedge pclk);
            #1;
            n++;
            if (smp_out_valid === 1'b1) k++;
        end
        if (k < 2) begin
            failures++;
            tally_and_finish;
        end
        chk({nm, "_l"}, {8'h00, smp_out.ch[0]}, {8'h00, el});
        chk({nm, "_r"}, {8'h00, smp_out.ch[1]}, {8'h00, eg});
    endtask

    // Write ctl1, poll status until the ramp ends, judge its length
    task ramp(input logic [31:0] c1, input int sps, input int steps,
              input logic [7:0] fin);
        int v0, n, len;
        apb(1'b1, dsmv_pkg::IDX_CTL1, c1);
        v0 = vcount;
        n = 0;
        do begin
            apb(1'b0, dsmv_pkg::IDX_STATUS, 32'h0);
            n++;
        end while (rd[16] !== 1'b0 && n < 20000);
        if (n >= 20000) begin
            failures++;
            tally_and_finish;
        end
        len = vcount - v0;
        chk("ramp_len", {31'h0, (len >= steps * sps - sps - 1) &&
            (len <= steps * sps + sps + 4)}, 32'h1);
        chk("ramp_end", {24'h0, rd[7:0]}, {24'h0, fin});
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        src_l = 24'h0003E8;
        src_r = 24'h0003E8;
        failures = 0;
        check_count = 0;
        vcount = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctl1", dsmv_pkg::IDX_CTL1, 32'h00000018);
        rdchk("alias", dsmv_pkg::IDX_ALIAS, 32'h00000010);
        out_chk("rst_out", 24'h0, 24'h0);
        apb(1'b1, 10'h007, 32'hFFFFFFFF);
        chk("unmapped", {31'h0, er}, 32'h1);
        // New track: hard unmute through the alias location
        apb(1'b1, dsmv_pkg::IDX_CTL2, 32'h0);
        apb(1'b1, dsmv_pkg::IDX_ALIAS, 32'h0);
        rdchk("ctl1_alias", dsmv_pkg::IDX_CTL1, 32'h00000010);
        out_chk("unmute", 24'h0003E8, 24'h0003E8);
        apb(1'b1, dsmv_pkg::IDX_CTL1, 32'h08);
        out_chk("hard_mute", 24'h0, 24'h0);
        rdchk("alias_ctl1", dsmv_pkg::IDX_ALIAS, 32'h00000010);
        apb(1'b1, dsmv_pkg::IDX_CTL1, 32'h0);
        // Gain codes wait for the strobe, then both apply
        apb(1'b1, dsmv_pkg::IDX_GAIN_L, 32'h0D0);
        out_chk("held", 24'h0003E8, 24'h0003E8);
        apb(1'b1, dsmv_pkg::IDX_GAIN_R, 32'h1B0);
        out_chk("gain", 24'h0007D0, 24'h0001F4);
        apb(1'b1, dsmv_pkg::IDX_GAIN_L, 32'h100);
        out_chk("code0", 24'h0, 24'h0001F4);
        apb(1'b1, dsmv_pkg::IDX_GAIN_L, 32'h0C0);
        apb(1'b1, dsmv_pkg::IDX_GAIN_R, 32'h1C0);
        // Fast soft mute, then slow soft unmute (resumed track)
        ramp(32'h18, 2, 192, 8'h00);
        out_chk("soft_muted", 24'h0, 24'h0);
        apb(1'b1, dsmv_pkg::IDX_CTL2, 32'h0C);
        ramp(32'h10, 32, 192, 8'hC0);
        out_chk("restored", 24'h0003E8, 24'h0003E8);
        // Reverse a fast mute ramp about 30 steps in; it climbs back from there
        apb(1'b1, dsmv_pkg::IDX_CTL2, 32'h08);
        apb(1'b1, dsmv_pkg::IDX_CTL1, 32'h18);
        repeat (240) @(posedge pclk);
        apb(1'b0, dsmv_pkg::IDX_STATUS, 32'h0);
        x = int'(rd[7:0]);
        chk("mid_ramp", {31'h0, rd[16] && x > 0 && x < 192}, 32'h1);
        ramp(32'h10, 2, 192 - x, 8'hC0);
        tally_and_finish;
    end
endmodule
